// File: design/frame_pkg.sv
// Constants for the register access frame builder and parser.
// What this block does
// - Frames open with marker A1EC, high byte first.
// - Byte 0x02 carries protocol revision 3.
// - Read response echoes command code 3.
// - Read response status byte holds result code.
// - Flags bit 0 set means ignore payload checksum.
// - Read response length equals returned payload bytes.
// - Read response carries start address at 0x0C.
// - Payload checksum CRC-32, poly 04C11DB7, start 0FFFFFFF.
// - Header checksum CCITT poly 1021, start zero.
// - Header checksum covers 0x02-0x3D, placed 0x3E.
// - Read payload from 0x40, words high byte first.
// - Zero reply address means reply to source address.
// - Zero reply port means reply to source port.
// - Only read or write commands with a good header get a response frame; others are dropped.
// - Accesses walk consecutive registers, one per word.
package frame_pkg;
   localparam logic [15:0] PREAMBLE       = 16'hA1EC;
   localparam logic [7:0]  PROTO_REV      = 8'h03;
   localparam logic [7:0]  CMD_READ       = 8'h03;
   localparam logic [7:0]  CMD_WRITE      = 8'h04;
   localparam logic [31:0] HDR_LEN        = 32'h0000_0040;
   localparam logic [5:0]  OFS_PRE_HI     = 6'h00;
   localparam logic [5:0]  OFS_PRE_LO     = 6'h01;
   localparam logic [5:0]  OFS_REV        = 6'h02;
   localparam logic [5:0]  OFS_CMD        = 6'h03;
   localparam logic [5:0]  OFS_STATUS     = 6'h05;
   localparam logic [5:0]  OFS_FLAGS_LO   = 6'h07;
   localparam logic [5:0]  OFS_LEN0       = 6'h08;
   localparam logic [5:0]  OFS_LEN3       = 6'h0B;
   localparam logic [5:0]  OFS_ADDR_HI    = 6'h0C;
   localparam logic [5:0]  OFS_ADDR_LO    = 6'h0D;
   localparam logic [5:0]  OFS_IP0        = 6'h11;
   localparam logic [5:0]  OFS_IP3        = 6'h14;
   localparam logic [5:0]  OFS_PORT0      = 6'h15;
   localparam logic [5:0]  OFS_PORT1      = 6'h16;
   localparam logic [5:0]  OFS_DCRC0      = 6'h3A;
   localparam logic [5:0]  OFS_DCRC3      = 6'h3D;
   localparam logic [5:0]  OFS_HCRC_HI    = 6'h3E;
   localparam logic [5:0]  OFS_HCRC_LO    = 6'h3F;
   localparam int          FLAG_IGN_BIT   = 0;
   localparam logic [15:0] CRC16_POLY     = 16'h1021;
   localparam logic [15:0] CRC16_INIT     = 16'h0000;
   localparam logic [31:0] CRC32_POLY     = 32'h04C1_1DB7;
   localparam logic [31:0] CRC32_INIT     = 32'h0FFF_FFFF;
   localparam logic [7:0]  STATUS_OK      = 8'h00;
   localparam logic [7:0]  STATUS_LEN_ERR = 8'h01;
   localparam logic [7:0]  STATUS_CRC_ERR = 8'h02;
   typedef enum logic [1:0]
   {
      ST_RX  = 2'b00,
      ST_SUM = 2'b01,
      ST_TX  = 2'b10
   } state_type;
endpackage

// File: design/frame_crc.sv
// Byte-wide MSB-first CRC register with selectable polynomial.
`timescale 1ns/100ps
module frame_crc
#(
   parameter int           W    = 16,
   parameter logic [W-1:0] POLY = '0,
   parameter logic [W-1:0] INIT = '0
)
(
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   // Byte feed
   input  wire logic         clear_i,
   input  wire logic         en_i,
   input  wire logic [7:0]   data_i,
   // Checksum
   output logic      [W-1:0] crc_o,
   output logic      [W-1:0] crc_nxt_o
);
   logic [W-1:0] crc_r;
   logic [W-1:0] crc_nxt;

   always_comb
   begin
      logic [W-1:0] c;
      c = crc_r;
      for (int i = 0; i < 8; i++)
      begin
         if (c[W-1] ^ data_i[7-i])
            c = {c[W-2:0], 1'b0} ^ POLY;
         else
            c = {c[W-2:0], 1'b0};
      end
      crc_nxt_o = c;
      if (clear_i)
         crc_nxt = INIT;
      else if (en_i)
         crc_nxt = c;
      else
         crc_nxt = crc_r;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         crc_r <= INIT;
      else
         crc_r <= crc_nxt;
   end

   assign crc_o = crc_r;
endmodule

// File: design/reg_frame_engine.sv
// Parses register read/write command frames and builds the responses.
`timescale 1ns/100ps
module reg_frame_engine
   import frame_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   // Received command bytes
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_valid_i,
   input  wire logic        rx_last_i,
   output logic             rx_ready_o,
   input  wire logic [31:0] src_ip_i,
   input  wire logic [15:0] src_port_i,
   // Response bytes
   output logic [7:0]       tx_data_o,
   output logic             tx_valid_o,
   output logic             tx_last_o,
   input  wire logic        tx_ready_i,
   output logic [31:0]      reply_ip_o,
   output logic [15:0]      reply_port_o,
   // Register port
   output logic [15:0]      reg_addr_o,
   output logic [15:0]      reg_wdata_o,
   output logic             reg_wr_o,
   output logic             reg_rd_o,
   input  wire logic [15:0] reg_rdata_i,
   // Status
   output logic             frame_drop_o
);
   import frame_pkg::*;

   state_type   state_r, state_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic [7:0]  cmd_r, cmd_nxt;
   logic        ign_r, ign_nxt;
   logic [31:0] len_r, len_nxt;
   logic [15:0] base_r, base_nxt;
   logic [31:0] cb_ip_r, cb_ip_nxt;
   logic [15:0] cb_port_r, cb_port_nxt;
   logic [31:0] dcrc_r, dcrc_nxt;
   logic [7:0]  hcrc_hi_r, hcrc_hi_nxt;
   logic        bad_r, bad_nxt;
   logic        hdr_ok_r, hdr_ok_nxt;
   logic [7:0]  status_r, status_nxt;
   logic [31:0] rlen_r, rlen_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [7:0]  lo_r, lo_nxt;
   logic [15:0] wdata_r, wdata_nxt;
   logic        wr_r, wr_nxt;
   logic [7:0]  txd_r, txd_nxt;
   logic [31:0] rip_r, rip_nxt;
   logic [15:0] rport_r, rport_nxt;
   logic        drop_r, drop_nxt;

   logic        rx_acc, tx_acc, in_hdr, hdr_now, good;
   logic [5:0]  ofs;
   logic [31:0] tx_idx, tx_end;
   logic        h16_clr, h16_en, h32_clr, h32_en, t16_en;
   logic [7:0]  h32_d;
   logic [15:0] h16_crc, t16_crc, t16_nxt;
   logic [31:0] c32, c32_nxt;

   frame_crc #(.W(16), .POLY(CRC16_POLY), .INIT(CRC16_INIT)) u_rx_hcrc
   (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .clear_i   (h16_clr),
      .en_i      (h16_en),
      .data_i    (rx_data_i),
      .crc_o     (h16_crc),
      .crc_nxt_o ()
   );

   frame_crc #(.W(16), .POLY(CRC16_POLY), .INIT(CRC16_INIT)) u_tx_hcrc
   (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .clear_i   (h16_clr),
      .en_i      (t16_en),
      .data_i    (txd_r),
      .crc_o     (t16_crc),
      .crc_nxt_o (t16_nxt)
   );

   frame_crc #(.W(32), .POLY(CRC32_POLY), .INIT(CRC32_INIT)) u_dcrc
   (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .clear_i   (h32_clr),
      .en_i      (h32_en),
      .data_i    (h32_d),
      .crc_o     (c32),
      .crc_nxt_o (c32_nxt)
   );

   // Header byte of the response at a given offset.
   function automatic logic [7:0] hdr_byte(input logic [5:0] o);
      logic [7:0] b;
      b = 8'h00;
      case (o)
         OFS_PRE_HI   : b = PREAMBLE[15:8];
         OFS_PRE_LO   : b = PREAMBLE[7:0];
         OFS_REV      : b = PROTO_REV;
         OFS_CMD      : b = cmd_r;
         OFS_STATUS   : b = status_r;
         OFS_FLAGS_LO : b = {7'h00, cmd_r == CMD_WRITE};
         6'h08        : b = rlen_r[31:24];
         6'h09        : b = rlen_r[23:16];
         6'h0A        : b = rlen_r[15:8];
         OFS_LEN3     : b = rlen_r[7:0];
         OFS_ADDR_HI  : b = base_r[15:8];
         OFS_ADDR_LO  : b = base_r[7:0];
         6'h3A        : b = (cmd_r == CMD_READ) ? c32[31:24] : 8'h00;
         6'h3B        : b = (cmd_r == CMD_READ) ? c32[23:16] : 8'h00;
         6'h3C        : b = (cmd_r == CMD_READ) ? c32[15:8] : 8'h00;
         OFS_DCRC3    : b = (cmd_r == CMD_READ) ? c32[7:0] : 8'h00;
         OFS_HCRC_HI  : b = t16_nxt[15:8];
         OFS_HCRC_LO  : b = t16_crc[7:0];
         default      : b = 8'h00;
      endcase
      return b;
   endfunction

   assign rx_acc   = rx_valid_i && rx_ready_o;
   assign tx_acc   = tx_valid_o && tx_ready_i;
   assign in_hdr   = (cnt_r[31:6] == 26'h0);
   assign ofs      = cnt_r[5:0];
   assign tx_idx   = cnt_r + 32'h1;
   assign tx_end   = HDR_LEN + rlen_r - 32'h1;
   // Header is judged on its last byte, from the checksum over 0x02-0x3D.
   assign hdr_now  = !bad_r && ({hcrc_hi_r, rx_data_i} == h16_crc);
   assign good     = (in_hdr && ofs == OFS_HCRC_LO) ? hdr_now
                   : (!in_hdr && hdr_ok_r);
   assign h16_clr  = (state_r == ST_RX) && rx_acc && cnt_r == 32'h0;
   assign h16_en   = rx_acc && in_hdr && ofs >= OFS_REV
                   && ofs <= OFS_DCRC3;
   assign t16_en   = (state_r == ST_TX) && tx_acc && in_hdr
                   && ofs >= OFS_REV && ofs <= OFS_DCRC3;
   assign rx_ready_o   = (state_r == ST_RX);
   assign tx_valid_o   = (state_r == ST_TX);
   assign tx_last_o    = tx_valid_o && (cnt_r == tx_end);
   assign tx_data_o    = txd_r;
   assign reply_ip_o   = rip_r;
   assign reply_port_o = rport_r;
   assign reg_addr_o   = addr_r;
   assign reg_wdata_o  = wdata_r;
   assign reg_wr_o     = wr_r;
   assign frame_drop_o = drop_r;

   always_comb
   begin
      state_nxt = state_r;    cnt_nxt = cnt_r;       cmd_nxt = cmd_r;
      ign_nxt = ign_r;        len_nxt = len_r;       base_nxt = base_r;
      cb_ip_nxt = cb_ip_r;    cb_port_nxt = cb_port_r;
      dcrc_nxt = dcrc_r;      hcrc_hi_nxt = hcrc_hi_r;
      bad_nxt = bad_r;        hdr_ok_nxt = hdr_ok_r; status_nxt = status_r;
      rlen_nxt = rlen_r;      addr_nxt = addr_r;     lo_nxt = lo_r;
      wdata_nxt = wdata_r;    wr_nxt = 1'b0;         txd_nxt = txd_r;
      rip_nxt = rip_r;        rport_nxt = rport_r;   drop_nxt = 1'b0;
      reg_rd_o = 1'b0;        h32_clr = 1'b0;        h32_en = 1'b0;
      h32_d = rx_data_i;
      if (wr_r)
         addr_nxt = addr_r + 16'h1;
      case (state_r)
         ST_RX:
         begin
            if (rx_acc)
            begin
               cnt_nxt = cnt_r + 32'h1;
               if (in_hdr)
               begin
                  if (ofs == OFS_PRE_HI && rx_data_i != PREAMBLE[15:8])
                     bad_nxt = 1'b1;
                  if (ofs == OFS_PRE_LO && rx_data_i != PREAMBLE[7:0])
                     bad_nxt = 1'b1;
                  if (ofs == OFS_REV && rx_data_i != PROTO_REV)
                     bad_nxt = 1'b1;
                  if (ofs == OFS_CMD)
                     cmd_nxt = rx_data_i;
                  if (ofs == OFS_FLAGS_LO)
                     ign_nxt = rx_data_i[FLAG_IGN_BIT];
                  if (ofs >= OFS_LEN0 && ofs <= OFS_LEN3)
                     len_nxt = {len_r[23:0], rx_data_i};
                  if (ofs == OFS_ADDR_HI)
                     base_nxt = {rx_data_i, base_r[7:0]};
                  if (ofs == OFS_ADDR_LO)
                     base_nxt = {base_r[15:8], rx_data_i};
                  if (ofs >= OFS_IP0 && ofs <= OFS_IP3)
                     cb_ip_nxt = {cb_ip_r[23:0], rx_data_i};
                  if (ofs == OFS_PORT0 || ofs == OFS_PORT1)
                     cb_port_nxt = {cb_port_r[7:0], rx_data_i};
                  if (ofs >= OFS_DCRC0 && ofs <= OFS_DCRC3)
                     dcrc_nxt = {dcrc_r[23:0], rx_data_i};
                  if (ofs == OFS_HCRC_HI)
                     hcrc_hi_nxt = rx_data_i;
                  if (ofs == OFS_HCRC_LO)
                  begin
                     hdr_ok_nxt = hdr_now;
                     addr_nxt = base_r;
                     h32_clr = 1'b1;
                  end
               end
               else if (hdr_ok_r && cmd_r == CMD_WRITE)
               begin
                  h32_en = 1'b1;
                  if (!cnt_r[0])
                     wdata_nxt = {rx_data_i, wdata_r[7:0]};
                  else
                  begin
                     wdata_nxt = {wdata_r[15:8], rx_data_i};
                     wr_nxt = 1'b1;
                  end
               end
               if (rx_last_i)
               begin
                  cnt_nxt = 32'h0;
                  bad_nxt = 1'b0;
                  hdr_ok_nxt = 1'b0;
                  rip_nxt = (cb_ip_r == 32'h0) ? src_ip_i : cb_ip_r;
                  rport_nxt = (cb_port_r == 16'h0) ? src_port_i
                                                   : cb_port_r;
                  txd_nxt = PREAMBLE[15:8];
                  // The address was loaded at the checksum byte; a write
                  // still pending from the last word must keep its step.
                  if (good && cmd_r == CMD_READ)
                  begin
                     status_nxt = STATUS_OK;
                     rlen_nxt = {len_r[31:1], 1'b0};
                     state_nxt = (len_r[31:1] == 31'h0) ? ST_TX : ST_SUM;
                  end
                  else if (good && cmd_r == CMD_WRITE)
                  begin
                     rlen_nxt = 32'h0;
                     if (len_r[0] || (cnt_r + 32'h1 != HDR_LEN + len_r)
                         || len_r == 32'h0)
                        status_nxt = STATUS_LEN_ERR;
                     else if (!ign_r && c32_nxt != dcrc_r)
                        status_nxt = STATUS_CRC_ERR;
                     else
                        status_nxt = STATUS_OK;
                     state_nxt = ST_TX;
                  end
                  else
                     drop_nxt = 1'b1;
               end
            end
         end
         ST_SUM:
         begin
            // First pass over the registers to form the payload checksum.
            h32_en = 1'b1;
            cnt_nxt = cnt_r + 32'h1;
            if (!cnt_r[0])
            begin
               reg_rd_o = 1'b1;
               h32_d = reg_rdata_i[15:8];
               lo_nxt = reg_rdata_i[7:0];
               addr_nxt = addr_r + 16'h1;
            end
            else
               h32_d = lo_r;
            if (cnt_r == rlen_r - 32'h1)
            begin
               cnt_nxt = 32'h0;
               addr_nxt = base_r;
               state_nxt = ST_TX;
            end
         end
         ST_TX:
         begin
            if (tx_acc)
            begin
               cnt_nxt = tx_idx;
               if (tx_last_o)
               begin
                  cnt_nxt = 32'h0;
                  state_nxt = ST_RX;
               end
               else if (tx_idx[31:6] == 26'h0)
                  txd_nxt = hdr_byte(tx_idx[5:0]);
               else if (!tx_idx[0])
               begin
                  reg_rd_o = 1'b1;
                  txd_nxt = reg_rdata_i[15:8];
                  lo_nxt = reg_rdata_i[7:0];
                  addr_nxt = addr_r + 16'h1;
               end
               else
                  txd_nxt = lo_r;
            end
         end
         default:
            state_nxt = ST_RX;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= ST_RX;   cnt_r <= 32'h0;     cmd_r <= 8'h00;
         ign_r <= 1'b0;      len_r <= 32'h0;     base_r <= 16'h0;
         cb_ip_r <= 32'h0;   cb_port_r <= 16'h0; dcrc_r <= 32'h0;
         hcrc_hi_r <= 8'h00; bad_r <= 1'b0;      hdr_ok_r <= 1'b0;
         status_r <= STATUS_OK;                  rlen_r <= 32'h0;
         addr_r <= 16'h0;    lo_r <= 8'h00;      wdata_r <= 16'h0;
         wr_r <= 1'b0;       txd_r <= 8'h00;     rip_r <= 32'h0;
         rport_r <= 16'h0;   drop_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;   cnt_r <= cnt_nxt;     cmd_r <= cmd_nxt;
         ign_r <= ign_nxt;       len_r <= len_nxt;     base_r <= base_nxt;
         cb_ip_r <= cb_ip_nxt;   cb_port_r <= cb_port_nxt;
         dcrc_r <= dcrc_nxt;     hcrc_hi_r <= hcrc_hi_nxt;
         bad_r <= bad_nxt;       hdr_ok_r <= hdr_ok_nxt;
         status_r <= status_nxt; rlen_r <= rlen_nxt;
         addr_r <= addr_nxt;     lo_r <= lo_nxt;       wdata_r <= wdata_nxt;
         wr_r <= wr_nxt;         txd_r <= txd_nxt;     rip_r <= rip_nxt;
         rport_r <= rport_nxt;   drop_r <= drop_nxt;
      end
   end
endmodule

// File: tb/frame_asserts.sv
// Concurrent checks on the ports of the register frame engine.
`timescale 1ns/100ps
module frame_asserts
(
   // Clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rst_n_i,
   // Command and response streams
   input wire logic        rx_valid_i,
   input wire logic        rx_last_i,
   input wire logic        rx_ready_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_valid_o,
   input wire logic        tx_last_o,
   input wire logic        tx_ready_i,
   input wire logic [31:0] reply_ip_o,
   input wire logic [15:0] reply_port_o,
   // Register port and status
   input wire logic [15:0] reg_addr_o,
   input wire logic        reg_wr_o,
   input wire logic        reg_rd_o,
   input wire logic        frame_drop_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_marker_high: assert property (
      $rose(tx_valid_o) |-> tx_data_o == 8'hA1) else $error("bad first byte");
   a_marker_low: assert property (
      $rose(tx_valid_o) && tx_ready_i |=> tx_data_o == 8'hEC)
      else $error("bad second byte");
   a_revision_byte: assert property (
      $rose(tx_valid_o) && tx_ready_i ##1 tx_ready_i |=> tx_data_o == 8'h03)
      else $error("bad revision byte");
   a_hold_byte: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("response byte dropped while stalled");
   a_rx_blocked: assert property (
      tx_valid_o |-> !rx_ready_o) else $error("accepting while answering");
   a_drop_cause: assert property (
      frame_drop_o |-> $past(rx_valid_i && rx_last_i && rx_ready_o))
      else $error("drop without a frame end");
   a_drop_silent: assert property (
      frame_drop_o |=> !tx_valid_o [*8]) else $error("reply to dropped frame");
   a_word_step: assert property (
      reg_wr_o ##2 reg_wr_o |-> reg_addr_o == $past(reg_addr_o, 2) + 16'h0001)
      else $error("write address did not advance by one");
   a_write_after_byte: assert property (
      reg_wr_o |-> $past(rx_valid_i && rx_ready_o))
      else $error("write without a taken byte");
   a_read_on_take: assert property (
      reg_rd_o && tx_valid_o |-> tx_ready_i) else $error("read while stalled");
   a_last_ends: assert property (
      tx_valid_o && tx_last_o && tx_ready_i |=> !tx_valid_o)
      else $error("response runs past its last byte");
   a_reply_fixed: assert property (
      tx_valid_o && $past(tx_valid_o) |-> $stable(reply_ip_o)
      && $stable(reply_port_o)) else $error("reply target moved");
endmodule

bind reg_frame_engine frame_asserts u_chk (.ref_clk_i, .rst_n_i, .rx_valid_i,
   .rx_last_i, .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_last_o, .tx_ready_i,
   .reply_ip_o, .reply_port_o, .reg_addr_o, .reg_wr_o, .reg_rd_o,
   .frame_drop_o);

// File: tb/host_model.sv
// Remote host model: streams command frames and collects response bytes.
`timescale 1ns/100ps
module host_model
(
   // Clock
   input  wire logic       ref_clk_i,
   // Command stream to the engine
   output logic [7:0]      rx_data_o,
   output logic            rx_valid_o,
   output logic            rx_last_o,
   input  wire logic       rx_ready_i,
   // Response stream from the engine
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   input  wire logic       tx_last_i,
   output logic            tx_ready_o
);
   logic [7:0] rsp_q[$];
   int         rsp_done = 0;
   int         tick = 0;
   logic       slow = 1'b0;
   initial
   begin
      rx_data_o  = 8'h00;
      rx_valid_o = 1'b0;
      rx_last_o  = 1'b0;
      tx_ready_o = 1'b1;
   end
   // A slow host takes one response byte in three.
   always @(negedge ref_clk_i)
   begin
      tick       <= tick + 1;
      tx_ready_o <= !slow || (tick % 3 == 0);
   end
   always @(posedge ref_clk_i)
      if (tx_valid_i && tx_ready_o)
      begin
         rsp_q.push_back(tx_data_i);
         if (tx_last_i)
            rsp_done++;
      end
   task automatic send(input logic [7:0] f[$], output bit ok);
      int n;
      ok = 1'b1;
      foreach (f[i])
      begin
         @(negedge ref_clk_i);
         rx_data_o  = f[i];
         rx_valid_o = 1'b1;
         rx_last_o  = (i == f.size() - 1);
         n = 0;
         while (!rx_ready_i && n < 900)
         begin
            @(negedge ref_clk_i);
            n++;
         end
         if (n == 900)
            ok = 1'b0;
      end
      @(negedge ref_clk_i);
      rx_valid_o = 1'b0;
      rx_last_o  = 1'b0;
      rx_data_o  = ~rx_data_o;
   endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the register frame engine.
`timescale 1ns/100ps
module testbench;
   import frame_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [7:0]  rx_data, tx_data;
   logic        rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
   logic        reg_wr, reg_rd, frame_drop;
   logic [31:0] src_ip = 32'h0A00_0002;
   logic [15:0] src_port = 16'h1234;
   logic [31:0] reply_ip, rip, wr_q[$];
   logic [15:0] reply_port, rport, reg_addr, reg_wdata, reg_rdata;
   logic [7:0]  f[$];
   int          failures = 0;
   int          samples_checked = 0;
   int          drops = 0;
   int          bad[3] = '{0, 2, 62};
   bit          ok;

   always #2.5 ref_clk_i = ~ref_clk_i;

   function automatic logic [15:0] rdv(input logic [15:0] a);
      return {a[7:0], ~a[15:8]};
   endfunction
   assign reg_rdata = rdv(reg_addr);

   always @(posedge ref_clk_i)
   begin
      if (reg_wr)
         wr_q.push_back({reg_addr, reg_wdata});
      if (frame_drop)
         drops++;
      if (tx_valid && tx_ready && tx_last)
         {rip, rport} = {reply_ip, reply_port};
   end

   reg_frame_engine u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_last_i(rx_last),
      .rx_ready_o(rx_ready), .src_ip_i(src_ip), .src_port_i(src_port),
      .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_last_o(tx_last),
      .tx_ready_i(tx_ready), .reply_ip_o(reply_ip), .reply_port_o(reply_port),
      .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
      .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .frame_drop_o(frame_drop));
   host_model u_host (.ref_clk_i(ref_clk_i), .rx_data_o(rx_data),
      .rx_valid_o(rx_valid), .rx_last_o(rx_last), .rx_ready_i(rx_ready),
      .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_last_i(tx_last),
      .tx_ready_o(tx_ready));

   // MSB-first checksum; the 16-bit one runs in the top half of the register.
   function automatic logic [31:0] crc(input logic [7:0] q[$],
                                       input int lo, hi, w);
      logic [31:0] c, p;
      c = (w == 16) ? {CRC16_INIT, 16'h0000} : CRC32_INIT;
      p = (w == 16) ? {CRC16_POLY, 16'h0000} : CRC32_POLY;
      for (int i = lo; i <= hi; i++)
      begin
         c ^= {q[i], 24'h000000};
         repeat (8) c = c[31] ? ((c << 1) ^ p) : (c << 1);
      end
      return (w == 16) ? {16'h0000, c[31:16]} : c;
   endfunction

   task automatic close_out;
      if (failures == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // Builds a command frame; bad_at names one byte to spoil, or -1.
   task automatic build(input logic [7:0] cmd, fl, input logic [15:0] len,
                        base, input logic [31:0] ip, input logic [15:0] port,
                        input int bad_at);
      f = {};
      repeat (64) f.push_back(8'h00);
      {f[0], f[1]} = PREAMBLE;
      f[2] = PROTO_REV;
      f[3] = cmd;
      f[7] = fl;
      {f[10], f[11]} = len;
      {f[12], f[13]} = base;
      f[16] = 8'h04;
      {f[17], f[18], f[19], f[20]} = ip;
      {f[21], f[22]} = port;
      if (cmd == CMD_WRITE)
         for (int i = 0; i < len; i++)
            f.push_back(8'(48 + i));
      {f[58], f[59], f[60], f[61]} = crc(f, 64, f.size() - 1, 32);
      if (bad_at >= 0)
         f[bad_at] = 8'h5A;
      if (bad_at != 62)
         {f[62], f[63]} = 16'(crc(f, 2, 61, 16));
   endtask

   task automatic run;
      int n, r0, d0;
      r0 = u_host.rsp_done;
      d0 = drops;
      wr_q = {};
      u_host.send(f, ok);
      n = 0;
      while (ok && u_host.rsp_done == r0 && drops == d0 && n < 900)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(32'(ok && n < 900), 1, "no answer");
      if (!ok || n == 900)
         close_out();
   endtask

   task automatic chk_rsp(input logic [7:0] cmd, st, fl,
                          input logic [15:0] len, base);
      logic [7:0] r[$];
      r = u_host.rsp_q;
      u_host.rsp_q = {};
      chk(r.size(), 64 + len, "response size");
      chk({r[0], r[1]}, PREAMBLE, "marker");
      chk(r[2], PROTO_REV, "revision");
      chk(r[3], cmd, "command");
      chk(r[5], st, "status");
      chk(r[7], fl, "flags");
      chk({r[8], r[9], r[10], r[11]}, len, "length");
      chk({r[62], r[63]}, crc(r, 2, 61, 16), "header sum");
      if (cmd == CMD_READ)
      begin
         chk({r[12], r[13]}, base, "address");
         chk({r[58], r[59], r[60], r[61]}, crc(r, 64, 63 + len, 32), "sum");
         for (int i = 0; i < len / 2; i++)
            chk({r[64 + 2 * i], r[65 + 2 * i]}, rdv(16'(base + i)), "word");
      end
   endtask

   task automatic wr_case(input logic [7:0] fl, input logic [15:0] len, base,
                          input logic [31:0] ip, input logic [15:0] port,
                          input int bad_at, input logic [7:0] st);
      build(CMD_WRITE, fl, len, base, ip, port, bad_at);
      run();
      chk(wr_q.size(), len / 2, "write count");
      for (int k = 0; k < len / 2; k++)
         chk(wr_q[k], {16'(base + k), 8'(48 + 2 * k), 8'(49 + 2 * k)}, "wr");
      chk_rsp(CMD_WRITE, st, 8'h01, 16'h0000, base);
      chk(rip, (ip != 0) ? ip : src_ip, "reply ip");
      chk(rport, (port != 0) ? port : src_port, "reply port");
   endtask

   initial
   begin
      repeat (3) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      wr_case(8'h01, 16'h0004, 16'h0120, 32'h0, 16'h0, -1, STATUS_OK);
      wr_case(8'h00, 16'h0004, 16'hFFFF, 32'hC0A8_0005, 16'h2233, -1,
              STATUS_OK);
      wr_case(8'h00, 16'h0002, 16'h0040, 32'h0, 16'h0, 58, STATUS_CRC_ERR);
      wr_case(8'h01, 16'h0002, 16'h0041, 32'h0, 16'h0, 58, STATUS_OK);
      wr_case(8'h01, 16'h0003, 16'h0050, 32'h0, 16'h0, -1,
              STATUS_LEN_ERR);
      u_host.slow = 1'b1;
      build(CMD_READ, 8'h00, 16'h0004, 16'h0200, 32'h0, 16'h0, -1);
      run();
      chk_rsp(CMD_READ, STATUS_OK, 8'h00, 16'h0004, 16'h0200);
      u_host.slow = 1'b0;
      build(CMD_READ, 8'h00, 16'h0006, 16'h7FFE, 32'h0, 16'h0, -1);
      run();
      chk_rsp(CMD_READ, STATUS_OK, 8'h00, 16'h0006, 16'h7FFE);
      foreach (bad[i])
      begin
         build(CMD_WRITE, 8'h01, 16'h0002, 16'h0300, 32'h0, 16'h0, bad[i]);
         run();
         chk(wr_q.size(), 0, "write from dropped frame");
         chk(u_host.rsp_q.size(), 0, "reply to dropped frame");
      end
      build(8'h07, 8'h01, 16'h0002, 16'h0300, 32'h0, 16'h0, -1);
      run();
      chk(wr_q.size(), 0, "write from unknown command");
      chk(u_host.rsp_q.size(), 0, "reply to unknown command");
      close_out();
   end
endmodule
